//--- src/eatpc_pkg.sv
package eatpc_pkg;

   // operating-mode field encodings
   localparam logic [2:0] MODE_OFF0      = 3'h0;   // module off
   localparam logic [2:0] MODE_TIMER     = 3'h1;   // general timer/counter
   localparam logic [2:0] MODE_OFF2      = 3'h2;   // module off
   localparam logic [2:0] MODE_OFF3      = 3'h3;   // module off
   localparam logic [2:0] MODE_IDX_X2    = 3'h4;   // reset on index, x2
   localparam logic [2:0] MODE_MATCH_X2  = 3'h5;   // reset on match, x2
   localparam logic [2:0] MODE_IDX_X4    = 3'h6;   // reset on index, x4
   localparam logic [2:0] MODE_MATCH_X4  = 3'h7;   // reset on match, x4

   // field positions inside the mode code
   localparam int MODE_ENC_BIT   = 2;              // set for all encoder modes
   localparam int MODE_MATCH_BIT = 0;              // set: reset on match
   localparam int MODE_X4_BIT    = 1;              // set: count every edge

   // reset values
   localparam logic [15:0] POS_RESET = 16'h0000;   // position count at reset
   localparam logic [15:0] ALL_ONES  = 16'hFFFF;   // down-count origin

   // timing: synchroniser depth in cycles
   localparam int SYNC_STAGES = 2;

   // configuration bundle travelling from ports into the core
   typedef struct packed {
      logic [2:0] mode;                 // operating_mode_field
      logic       dir_src;              // direction_source_select
      logic       sw_dir;               // software_direction_bit
      logic       clk_src;              // timer_clock_source_select
      logic       gate_en;              // timer_gate_enable
      logic       dir_out_en;           // direction_output_enable
      logic       stop_idle;            // stop_in_idle
      logic       err_irq_dis;          // count_error_irq_disable
   } eatpc_cfg_t;

   // synchronised and edge-detected pin view
   typedef struct packed {
      logic a_lvl;                      // phase A level
      logic b_lvl;                      // phase B level
      logic idx_lvl;                    // index level
      logic a_rise;                     // phase A rising pulse
      logic a_fall;                     // phase A falling pulse
      logic b_rise;                     // phase B rising pulse
      logic b_fall;                     // phase B falling pulse
      logic idx_rise;                   // index rising pulse
   } eatpc_pins_t;

endpackage

//--- src/eatpc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser per pin plus edge detector on the settled stage
module eatpc_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   // raw pins
   input  wire logic [WIDTH-1:0] pin_in,
   // settled levels and one-cycle edge pulses
   output logic      [WIDTH-1:0] lvl,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] s1_ff;            // first stage, read only by s2
   logic [WIDTH-1:0] s2_ff;            // settled stage
   logic [WIDTH-1:0] s3_ff;            // previous settled value
   logic [WIDTH-1:0] nxt_s1;
   logic [WIDTH-1:0] nxt_s2;
   logic [WIDTH-1:0] nxt_s3;

   // next values: plain shift
   always_comb
   begin
      nxt_s1 = pin_in;
      nxt_s2 = s1_ff;
      nxt_s3 = s2_ff;
   end

   // registers only
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end
      else
      begin
         s1_ff <= nxt_s1;
         s2_ff <= nxt_s2;
         s3_ff <= nxt_s3;
      end
   end

   // edges come from stages two and three only, never from stage one
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++)
      begin : g_edge
         assign lvl[gi]  = s2_ff[gi];
         assign rise[gi] = s2_ff[gi] & ~s3_ff[gi];  // [R24]
         assign fall[gi] = ~s2_ff[gi] & s3_ff[gi];  // [R24]
      end
   endgenerate

endmodule // eatpc_sync
`default_nettype wire

//--- src/eatpc_quad.sv
`timescale 1ns/1ps
`default_nettype none
// quadrature step decoder: compares each new state with the last seen one
module eatpc_quad (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // controls
   input  wire logic run,              // low while halted: state frozen
   input  wire logic x4,               // count every edge, else only phase A edges
   // settled phases
   input  wire logic a_lvl,
   input  wire logic b_lvl,
   // step outputs, one-cycle pulses
   output logic      step_up,
   output logic      step_dn,
   output logic      dir_up            // last direction seen
);

   logic [1:0] last_ff;                // last accepted phase state
   logic [1:0] nxt_last;
   logic       dir_ff;
   logic       nxt_dir;
   logic [1:0] cur;
   logic       fwd;
   logic       rev;

   assign cur = {a_lvl, b_lvl};

   // forward: gray sequence 00 -> 10 -> 11 -> 01; halted the old state is kept,
   // so the first transition after wake-up is judged against it
   always_comb
   begin
      fwd = ({last_ff, cur} == 4'b0010) || ({last_ff, cur} == 4'b1011) ||
            ({last_ff, cur} == 4'b1101) || ({last_ff, cur} == 4'b0100);
      rev = ({last_ff, cur} == 4'b0001) || ({last_ff, cur} == 4'b0111) ||
            ({last_ff, cur} == 4'b1110) || ({last_ff, cur} == 4'b1000);
      nxt_last = run ? cur : last_ff;                      // [R20]
      nxt_dir  = dir_ff;
      if (run && fwd)
         nxt_dir = 1'b1;
      else if (run && rev)
         nxt_dir = 1'b0;
      // x2 counts only on phase A changes
      step_up = run && fwd && (x4 || (last_ff[1] != cur[1]));
      step_dn = run && rev && (x4 || (last_ff[1] != cur[1]));
   end

   // registers only
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         last_ff <= 2'b00;                                 // [R22]
         dir_ff  <= 1'b1;
      end
      else
      begin
         last_ff <= nxt_last;
         dir_ff  <= nxt_dir;
      end
   end

   assign dir_up = dir_ff;

endmodule // eatpc_quad
`default_nettype wire

//--- src/eatpc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (R1) mode 001 runs 16-bit timer, max_count period
// (R2) timer mode bypasses input noise filters
// (R3) timer match asserts encoder event flag
// (R4) mode switches keep counter contents
// (R5) up count: match clears to zero
// (R6) down count: match clears to zero
// (R7) software loads period 0xFFFF minus length
// (R8) direction source 1: phase B sets direction
// (R9) direction source 0: software bit sets direction
// (R10) external clock: synchronised phase A edges
// (R11) gate enable: phase A gates internal clock
// (R12) clock and gate both set: interrupt, hold
// (R13) match modes interrupt on rollover, underflow
// (R14) index modes interrupt on index, error
// (R15) timer interrupts on match, gate fall
// (R16) interrupt flag sticky until software clears
// (R17) enabled module owns its used pins
// (R18) off modes release pins; direction output gated
// (R19) sleep halts counter and ignores pins
// (R20) after wake, judge against last state
// (R21) idle halts only when stop_in_idle set
// (R22) reset restores registers, decoder and counter
// (R23) count error interrupts unless disabled
// (R24) synchronise and edge-detect clock and gate
module eatpc_top (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   // configuration bits
   input  wire eatpc_pkg::eatpc_cfg_t cfg,
   input  wire logic [15:0]           max_count,
   input  wire logic                  pos_load,        // software write of the counter
   input  wire logic [15:0]           pos_load_val,
   input  wire logic                  filter_en,       // encoder noise filter requested
   // power state
   input  wire logic                  sleep_mode,
   input  wire logic                  idle_mode,
   // software clears, one-cycle pulses
   input  wire logic                  irq_flag_clr,
   input  wire logic                  event_flag_clr,
   input  wire logic                  count_error_clr,
   // pins
   input  wire logic                  phase_a_pin,
   input  wire logic                  phase_b_pin,
   input  wire logic                  index_pin,
   // pin ownership
   output logic                       own_phase_a,
   output logic                       own_phase_b,
   output logic                       own_index,
   output logic                       direction_status_out,
   output logic                       direction_status_oe,
   // status
   output logic [15:0]                position_count,
   output logic                       encoder_event_flag,
   output logic                       encoder_irq_flag,
   output logic                       count_error_flag,
   output logic                       filter_active,
   output logic                       index_level
);

   logic [2:0] lvl;
   logic [2:0] rise;
   logic [2:0] fall;
   logic       step_up;
   logic       step_dn;
   logic       dir_up;
   logic       is_timer;
   logic       is_enc;
   logic       is_match;
   logic       halted;
   logic       run;
   logic       tick;
   logic       t_up;
   logic       t_match;
   logic       both_sel;
   logic       gate_fall;
   logic       enc_roll;
   logic       enc_under;
   logic       idx_hit;
   logic       err_hit;
   logic       irq_evt;
   logic [15:0] pos_ff;                 // position_count register
   logic [15:0] nxt_pos;
   logic        evt_ff;                 // encoder event flag
   logic        nxt_evt;
   logic        irq_ff;                 // interrupt flag
   logic        nxt_irq;
   logic        err_ff;                 // count error flag
   logic        nxt_err;
   logic        both_ff;                // previous clock-and-gate state
   logic        nxt_both;
   logic        dout_ff;                // direction pin data
   logic        nxt_dout;

   // pins are synchronised once; used raw, no filter stage
   eatpc_sync #(
      .WIDTH  (3)
   ) u_sync (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .pin_in  ({index_pin, phase_b_pin, phase_a_pin}),
      .lvl     (lvl),
      .rise    (rise),
      .fall    (fall)
   );

   // mode decode
   assign is_timer = (cfg.mode == eatpc_pkg::MODE_TIMER);                 // [R1]
   assign is_enc   = cfg.mode[eatpc_pkg::MODE_ENC_BIT];
   assign is_match = is_enc && cfg.mode[eatpc_pkg::MODE_MATCH_BIT];

   // halt on sleep, or on idle with stop_in_idle; pins then ignored
   assign halted = sleep_mode || (idle_mode && cfg.stop_idle);            // [R19] [R21]
   assign run    = !halted;

   eatpc_quad u_quad (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .run     (run && is_enc),
      .x4      (cfg.mode[eatpc_pkg::MODE_X4_BIT]),
      .a_lvl   (lvl[0]),
      .b_lvl   (lvl[1]),
      .step_up (step_up),
      .step_dn (step_dn),
      .dir_up  (dir_up)
   );

   // filter requested but forced off in timer mode
   assign filter_active = filter_en && is_enc;                            // [R2]
   assign index_level   = lvl[2];

   // timer tick source: clock and gate together blocks counting
   always_comb
   begin
      both_sel  = cfg.clk_src && cfg.gate_en;
      gate_fall = run && is_timer && cfg.gate_en && !cfg.clk_src && fall[0];
      if (!run || !is_timer || both_sel)                                  // [R12]
         tick = 1'b0;
      else if (cfg.clk_src)
         tick = rise[0];                                                  // [R10]
      else if (cfg.gate_en)
         tick = lvl[0];                                                   // [R11]
      else
         tick = 1'b1;
      // direction select
      t_up    = cfg.dir_src ? lvl[1] : cfg.sw_dir;                        // [R8] [R9]
      t_match = (pos_ff == max_count);
   end

   // encoder boundary events
   always_comb
   begin
      enc_roll  = is_match && step_up && (pos_ff == max_count);
      enc_under = is_match && step_dn && (pos_ff == eatpc_pkg::POS_RESET);
      idx_hit   = run && is_enc && !is_match && rise[2];
      err_hit   = run && is_enc && !is_match && !err_ff &&
                  ((step_up && (pos_ff == max_count)) ||
                   (step_dn && (pos_ff == eatpc_pkg::POS_RESET)));
   end

   // counter next value; mode changes never touch it
   always_comb
   begin
      nxt_pos = pos_ff;                                                   // [R4]
      if (pos_load)
         nxt_pos = pos_load_val;
      else if (tick)
      begin
         if (t_match)
            nxt_pos = eatpc_pkg::POS_RESET;                               // [R5] [R6]
         else if (t_up)
            nxt_pos = pos_ff + 16'h0001;                                  // [R5]
         else
            nxt_pos = pos_ff - 16'h0001;                                  // [R6]
      end
      else if (enc_roll)
         nxt_pos = eatpc_pkg::POS_RESET;                                  // [R13]
      else if (enc_under)
         nxt_pos = max_count;                                             // [R13]
      else if (idx_hit)
         nxt_pos = dir_up ? eatpc_pkg::POS_RESET : max_count;
      else if (step_up)
         nxt_pos = pos_ff + 16'h0001;
      else if (step_dn)
         nxt_pos = pos_ff - 16'h0001;
   end

   // flags: a set in the clearing cycle wins
   always_comb
   begin
      nxt_both = both_sel && is_timer && run;
      nxt_evt  = evt_ff;
      if (event_flag_clr)
         nxt_evt = 1'b0;
      if (tick && t_match)
         nxt_evt = 1'b1;                                                  // [R3]
      nxt_err = err_ff;
      if (count_error_clr)
         nxt_err = 1'b0;
      if (err_hit)
         nxt_err = 1'b1;
      irq_evt = (tick && t_match) || gate_fall ||                         // [R15]
                (nxt_both && !both_ff) ||                                 // [R12]
                enc_roll || enc_under ||                                  // [R13]
                idx_hit ||                                                // [R14]
                (err_hit && !cfg.err_irq_dis);                            // [R23] [R14]
      nxt_irq = irq_ff;
      if (irq_flag_clr)
         nxt_irq = 1'b0;
      if (irq_evt)
         nxt_irq = 1'b1;                                                  // [R16]
      nxt_dout = is_enc ? dir_up : 1'b0;
   end

   // registers only; all state returns to reset values
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pos_ff  <= eatpc_pkg::POS_RESET;                                 // [R22]
         evt_ff  <= 1'b0;
         irq_ff  <= 1'b0;
         err_ff  <= 1'b0;
         both_ff <= 1'b0;
         dout_ff <= 1'b0;
      end
      else
      begin
         pos_ff  <= nxt_pos;
         evt_ff  <= nxt_evt;
         irq_ff  <= nxt_irq;
         err_ff  <= nxt_err;
         both_ff <= nxt_both;
         dout_ff <= nxt_dout;
      end
   end

   // pin ownership follows the mode table
   always_comb
   begin
      own_phase_a = is_enc || (is_timer && (cfg.clk_src || cfg.gate_en)); // [R17] [R18]
      own_phase_b = is_enc || (is_timer && cfg.dir_src);                  // [R17]
      own_index   = is_enc && !is_match;                                  // [R17]
      direction_status_oe = is_enc && cfg.dir_out_en;                     // [R18]
   end

   assign direction_status_out = dout_ff;
   assign position_count       = pos_ff;
   assign encoder_event_flag   = evt_ff;
   assign encoder_irq_flag     = irq_ff;
   assign count_error_flag     = err_ff;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   // timer match clears the count on the following edge
   property p_match_clear;
      (tick && t_match && !pos_load) |=> (position_count == 16'h0000);
   endproperty
   a_match_clear: assert property (p_match_clear) else $error("match no clear"); // [R5]

   property p_evt_set;
      (is_timer && run && !both_sel && tick && t_match) |=> encoder_event_flag;
   endproperty
   a_evt_set: assert property (p_evt_set) else $error("event flag missed"); // [R3]

   property p_irq_sticky;
      (encoder_irq_flag && !irq_flag_clr) |=> encoder_irq_flag;
   endproperty
   a_irq_sticky: assert property (p_irq_sticky) else $error("irq flag dropped"); // [R16]

   property p_halt_hold;
      (sleep_mode && !pos_load) |=> $stable(position_count);
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("count moved in sleep"); // [R19]

   property p_both_hold;
      (is_timer && both_sel && !pos_load) |=> $stable(position_count);
   endproperty
   a_both_hold: assert property (p_both_hold) else $error("count moved with both set"); // [R12]

   property p_up_step;
      (tick && !t_match && t_up && !pos_load) |=>
         (position_count == $past(position_count) + 16'h0001);
   endproperty
   a_up_step: assert property (p_up_step) else $error("bad up step"); // [R8]

   property p_dn_step;
      (tick && !t_match && !t_up && !pos_load) |=>
         (position_count == $past(position_count) - 16'h0001);
   endproperty
   a_dn_step: assert property (p_dn_step) else $error("bad down step"); // [R6]

   property p_off_release;
      (!is_enc && !is_timer) |-> !(own_phase_a || own_phase_b || own_index ||
                                   direction_status_oe);
   endproperty
   a_off_release: assert property (p_off_release) else $error("pins held while off"); // [R18]

   property p_gate_irq;
      gate_fall |=> encoder_irq_flag;
   endproperty
   a_gate_irq: assert property (p_gate_irq) else $error("gate fall irq missed"); // [R15]

   property p_err_mask;
      (err_hit && !cfg.err_irq_dis) |=> encoder_irq_flag;
   endproperty
   a_err_mask: assert property (p_err_mask) else $error("error irq missed"); // [R23]

endmodule // eatpc_top
`default_nettype wire

//--- sim/eatpc_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side stand-in: encoder phases, index, and a clock or gate on phase a
module eatpc_enc_model (
   // used only to place pin changes just after an edge
   input  wire logic ref_clk,
   // pins towards the block
   output var logic  phase_a_pin,
   output var logic  phase_b_pin,
   output var logic  index_pin
);
   // rest state: all low
   initial
   begin
      phase_a_pin = 1'b0;
      phase_b_pin = 1'b0;
      index_pin   = 1'b0;
   end
   // let n edges pass, then settle off the edge
   task automatic edges(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   // level on phase b, read as direction in timer mode
   task automatic set_b(input logic v);
      phase_b_pin = v;
      edges(4);
   endtask
   // clock or gate train, each pulse wide enough to be synchronised
   task automatic pulse_a(input int n, input int hi, input int lo);
      repeat (n)
      begin
         phase_a_pin = 1'b1;
         edges(hi);
         phase_a_pin = 1'b0;
         edges(lo);
      end
   endtask
   // one gray step; up means phase a leads phase b
   task automatic step(input logic up);
      if ((phase_a_pin == phase_b_pin) == up)
         phase_a_pin = ~phase_a_pin;
      else
         phase_b_pin = ~phase_b_pin;
      edges(5);
   endtask
   // index pulse three cycles wide
   task automatic index_pulse();
      index_pin = 1'b1;
      edges(3);
      index_pin = 1'b0;
      edges(4);
   endtask
endmodule // eatpc_enc_model
`default_nettype wire

//--- sim/test_encoder_aux_timer_and_pin_control.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the encoder timer block
module test_encoder_aux_timer_and_pin_control;
   // bench-driven inputs
   logic                  ref_clk;
   logic                  rstn;
   eatpc_pkg::eatpc_cfg_t cfg;
   logic [15:0]           max_count;
   logic                  pos_load;
   logic [15:0]           pos_load_val;
   logic                  filter_en;
   logic                  sleep_mode;
   logic                  idle_mode;
   logic                  irq_flag_clr;
   logic                  event_flag_clr;
   logic                  count_error_clr;
   // pins from the far-side model
   logic                  phase_a_pin;
   logic                  phase_b_pin;
   logic                  index_pin;
   // design outputs
   logic                  own_phase_a;
   logic                  own_phase_b;
   logic                  own_index;
   logic                  direction_status_out;
   logic                  direction_status_oe;
   logic [15:0]           position_count;
   logic                  encoder_event_flag;
   logic                  encoder_irq_flag;
   logic                  count_error_flag;
   logic                  filter_active;
   logic                  index_level;
   // bookkeeping
   int                    err_total;
   int                    compares;
   logic [15:0]           c;
   // ownership rows: {mode, dir_src, gate_en, clk_src, dir_out_en, filter_en}
   logic [7:0]            row_in [10];
   // expected {own_a, own_b, own_index, dir oe, filter_active}
   logic [4:0]            row_exp [10];

   eatpc_top dut (.*);

   eatpc_enc_model enc (.*);

   // 25 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // n edges, then step off the edge so inputs never race it
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   // single comparison point
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // verdict and end of run
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // software write of the counter
   task automatic load(input logic [15:0] v);
      pos_load     = 1'b1;
      pos_load_val = v;
      tick(1);
      pos_load     = 1'b0;
   endtask
   // one-cycle clear pulses on all sticky flags
   task automatic clr_flags();
      irq_flag_clr    = 1'b1;
      event_flag_clr  = 1'b1;
      count_error_clr = 1'b1;
      tick(1);
      irq_flag_clr    = 1'b0;
      event_flag_clr  = 1'b0;
      count_error_clr = 1'b0;
   endtask
   // internal-clock timer: one count a cycle, match clears to zero
   task automatic run_seq(input int n, input logic up);
      logic [15:0] prev;
      logic [15:0] exp;
      repeat (n)
      begin
         prev = position_count;
         tick(1);
         exp = (prev == max_count) ? 16'h0000 : (up ? prev + 16'h0001 : prev - 16'h0001);
         check("timer count", position_count, exp);
         if (prev == max_count)
            check("match flags", {14'h0000, encoder_event_flag, encoder_irq_flag}, 16'h0003);
      end
   endtask

   // watchdog: the whole sequence needs well under 2000 cycles
   initial
   begin
      #800000;
      err_total++;
      wrap_up();
   end

   // main sequence
   initial
   begin
      row_in  = '{8'h1F, 8'h5F, 8'h7F, 8'h23, 8'h3B, 8'h24, 8'hA3, 8'hC1, 8'h82, 8'hE0};
      row_exp = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h18, 5'h10, 5'h1B, 5'h1D, 5'h1E, 5'h18};
      err_total = 0;
      compares = 0;
      rstn = 1'b0;
      cfg = '0;
      max_count = 16'hFFFF;
      pos_load = 1'b0;
      pos_load_val = 16'h0000;
      filter_en = 1'b0;
      sleep_mode = 1'b0;
      idle_mode = 1'b0;
      irq_flag_clr = 1'b0;
      event_flag_clr = 1'b0;
      count_error_clr = 1'b0;
      tick(8);
      rstn = 1'b1;
      check("reset state", {10'h000, position_count == 16'h0000, encoder_event_flag,
         encoder_irq_flag, count_error_flag, direction_status_out, 1'b0}, 16'h0020);
      // pin ownership and filter bypass per mode
      for (int i = 0; i < 10; i++)
      begin
         {cfg.mode, cfg.dir_src, cfg.gate_en, cfg.clk_src, cfg.dir_out_en, filter_en} = row_in[i];
         #1;
         check("pin ownership", {11'h000, own_phase_a, own_phase_b, own_index,
            direction_status_oe, filter_active}, {11'h000, row_exp[i]});
      end
      $display("test ownership done");
      tick(1);
      cfg = '0;
      filter_en = 1'b1;
      cfg.mode = eatpc_pkg::MODE_TIMER;
      cfg.sw_dir = 1'b1;
      max_count = 16'h0004;
      load(16'h0000);
      clr_flags();
      run_seq(12, 1'b1);
      check("irq held", {15'h0000, encoder_irq_flag}, 16'h0001);
      event_flag_clr = 1'b1;
      tick(1);
      event_flag_clr = 1'b0;
      check("event clear", {14'h0000, encoder_event_flag, encoder_irq_flag}, 16'h0001);
      irq_flag_clr = 1'b1;
      tick(1);
      irq_flag_clr = 1'b0;
      check("set wins", {14'h0000, encoder_event_flag, encoder_irq_flag}, 16'h0003);
      cfg.sw_dir = 1'b0;
      max_count = 16'hFFF0;
      load(16'h0000);
      clr_flags();
      run_seq(20, 1'b0);
      $display("test timer up down done");
      cfg.dir_src = 1'b1;
      max_count = 16'hFFFF;
      load(16'h0100);
      enc.set_b(1'b1);
      run_seq(3, 1'b1);
      enc.set_b(1'b0);
      run_seq(3, 1'b0);
      $display("test phase b direction done");
      cfg.dir_src = 1'b0;
      cfg.sw_dir = 1'b1;
      cfg.mode = eatpc_pkg::MODE_OFF0;
      tick(2);
      c = position_count;
      tick(4);
      check("count while off", position_count, c);
      cfg.mode = eatpc_pkg::MODE_MATCH_X4;
      tick(4);
      check("count in encoder mode", position_count, c);
      cfg.mode = eatpc_pkg::MODE_TIMER;
      for (int i = 0; i < 8 && position_count === c; i++)
         tick(1);
      check("count resumes", position_count, c + 16'h0001);
      $display("test mode switch done");
      cfg.clk_src = 1'b1;
      tick(4);
      c = position_count;
      enc.pulse_a(5, 3, 3);
      check("external edges", position_count, c + 16'h0005);
      cfg.clk_src = 1'b0;
      cfg.gate_en = 1'b1;
      tick(4);
      clr_flags();
      c = position_count;
      tick(4);
      check("gate closed", position_count, c);
      enc.pulse_a(1, 10, 6);
      check("gated count", position_count, c + 16'h000A);
      check("gate fall irq", {15'h0000, encoder_irq_flag}, 16'h0001);
      clr_flags();
      cfg.clk_src = 1'b1;
      tick(3);
      check("conflict irq", {15'h0000, encoder_irq_flag}, 16'h0001);
      c = position_count;
      enc.pulse_a(3, 3, 3);
      check("conflict hold", position_count, c);
      $display("test clock and gate done");
      cfg.gate_en = 1'b0;
      sleep_mode = 1'b1;
      tick(2);
      c = position_count;
      enc.pulse_a(3, 3, 3);
      check("sleep hold", position_count, c);
      sleep_mode = 1'b0;
      cfg.clk_src = 1'b0;
      tick(2);
      idle_mode = 1'b1;
      run_seq(4, 1'b1);
      cfg.stop_idle = 1'b1;
      tick(2);
      c = position_count;
      tick(4);
      check("idle stop", position_count, c);
      idle_mode = 1'b0;
      cfg.stop_idle = 1'b0;
      $display("test power states done");
      cfg = '0;
      cfg.mode = eatpc_pkg::MODE_MATCH_X4;
      cfg.dir_out_en = 1'b1;
      max_count = 16'h0003;
      load(16'h0000);
      clr_flags();
      repeat (5) enc.step(1'b1);
      check("rollover", {position_count[13:0], encoder_irq_flag, direction_status_out}, 16'h0007);
      clr_flags();
      repeat (2) enc.step(1'b0);
      check("underflow", {position_count[13:0], encoder_irq_flag, direction_status_out}, 16'h000E);
      cfg.mode = eatpc_pkg::MODE_IDX_X4;
      max_count = 16'h0009;
      load(16'h0005);
      clr_flags();
      fork
         enc.index_pulse();
         begin
            tick(3);
            check("index level", {15'h0000, index_level}, 16'h0001);
         end
      join
      check("index reset", {position_count[14:0], encoder_irq_flag}, 16'h0013);
      clr_flags();
      load(16'h0009);
      enc.step(1'b1);
      check("count error irq", {14'h0000, count_error_flag, encoder_irq_flag}, 16'h0003);
      cfg.err_irq_dis = 1'b1;
      clr_flags();
      load(16'h0009);
      enc.step(1'b1);
      check("error irq off", {14'h0000, count_error_flag, encoder_irq_flag}, 16'h0002);
      $display("test encoder modes done");
      rstn = 1'b0;
      #1;
      check("mid reset", {11'h000, position_count == 16'h0000, encoder_event_flag,
         encoder_irq_flag, count_error_flag, direction_status_out}, 16'h0010);
      tick(2);
      rstn = 1'b1;
      $display("test second reset done");
      wrap_up();
   end
endmodule // test_encoder_aux_timer_and_pin_control
`default_nettype wire
